// >>> design/rtctc_pkg.sv
package rtctc_pkg;

	// ***************************************************************
	// register map
	// ***************************************************************
	localparam logic [7:0] TRIM_ENABLE_ADDR  = 8'h1f;
	localparam logic [7:0] TRIM_AMOUNT_ADDR  = 8'h20;
	localparam logic [7:0] CLOCK_OUTPUT_ADDR = 8'h21;
	localparam logic [7:0] REG_RESET_VAL     = 8'h00;

	localparam int TRIM_ENABLE_BIT = 0;
	localparam int TRIM_AMOUNT_LSB = 0;
	localparam int TRIM_AMOUNT_W   = 6;
	localparam int TRIM_SIGN_BIT   = 6;
	localparam int CLK_MASK_BIT    = 0;

	// ***************************************************************
	// timing
	// ***************************************************************
	localparam int CLK_HZ        = 100_000_000;
	localparam int SLOW_HZ       = 32_768;
	localparam int HALF_CYC      = CLK_HZ / (2 * SLOW_HZ);
	localparam int TICKS_PER_SEC = 32_768;
	localparam int WINDOW_SECS   = 64;
	localparam int SEC_W         = 32;

endpackage

// >>> design/rtctc_top.sv
`timescale 1ns/100ps
`default_nettype none
// How it works
// - trim enable bit turns correction on
// - amount seconds corrected per 64-second window
// - sign bit: add or subtract seconds
// - mask bit silences the 32 kHz output
// - three registers read/write, reset to zero
// - on backup power the clock keeps counting
module rtctc_top #(
	parameter int TICKS_PER_SEC = rtctc_pkg::TICKS_PER_SEC
) (
	input  wire logic                       clk,
	input  wire logic                       resetn,
	input  wire logic                       on_backup,
	input  wire logic [7:0]                 reg_addr,
	input  wire logic [7:0]                 reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic      [7:0]                 reg_rdata,
	output logic                            clk32k_out,
	output logic                            sec_pulse,
	output logic      [rtctc_pkg::SEC_W-1:0] sec_count
);
	import rtctc_pkg::*;

	localparam int DIV_W  = $clog2(HALF_CYC + 1);
	localparam int TICK_W = $clog2(TICKS_PER_SEC + 1);

	typedef struct packed {
		logic                     trim_en;
		logic [TRIM_AMOUNT_W-1:0] trim_amount;
		logic                     trim_sign;
		logic                     clk_mask;
		logic [DIV_W-1:0]         div_cnt;
		logic                     slow_clk;
		logic [TICK_W-1:0]        tick_cnt;
		logic [5:0]               win_cnt;
		logic [SEC_W-1:0]         secs;
		logic                     pulse;
		logic                     clk_out;
		logic [7:0]               rdata;
	} rtctc_state_t;

	// ***************************************************************
	// reset release and pin synchroniser
	// ***************************************************************
	logic [1:0] rst_sync_q;
	logic       rst_n;
	logic [1:0] bk_sync_q;
	logic       backup;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bk_sync_q <= 2'h0;
		end else begin
			bk_sync_q <= {bk_sync_q[0], on_backup};
		end
	end
	assign backup = bk_sync_q[1];

	// ***************************************************************
	// next state
	// ***************************************************************
	rtctc_state_t st_q;
	rtctc_state_t st_d;
	logic         half_done;
	logic         tick32;
	logic         sec_tick;
	logic         trim_hit;
	logic         bus_ok;

	always_comb begin
		st_d      = st_q;
		// registers live on the keep-alive supply, so no access while on backup
		bus_ok    = !backup;
		half_done = (st_q.div_cnt == DIV_W'(HALF_CYC - 1));
		tick32    = half_done && !st_q.slow_clk;
		sec_tick  = tick32 && (st_q.tick_cnt == TICK_W'(TICKS_PER_SEC - 1));
		trim_hit  = st_q.trim_en && (st_q.win_cnt < st_q.trim_amount);

		st_d.div_cnt = half_done ? '0 : st_q.div_cnt + DIV_W'(1);
		if (half_done) begin
			st_d.slow_clk = !st_q.slow_clk;
		end
		if (tick32) begin
			st_d.tick_cnt = sec_tick ? '0 : st_q.tick_cnt + TICK_W'(1);
		end

		// counting runs regardless of supply state
		st_d.pulse = 1'b0;
		if (sec_tick) begin
			st_d.win_cnt = st_q.win_cnt + 6'h01;
			if (!trim_hit) begin
				st_d.secs  = st_q.secs + SEC_W'(1);
				st_d.pulse = 1'b1;
			end else if (!st_q.trim_sign) begin
				// add: this second counts twice
				st_d.secs  = st_q.secs + SEC_W'(2);
				st_d.pulse = 1'b1;
			end else begin
				// subtract: this second is swallowed, no pulse
				st_d.secs  = st_q.secs;
			end
		end

		// system side is unpowered on backup, so the clock pin stays low
		st_d.clk_out = st_d.slow_clk && !st_q.clk_mask && !backup;

		if (reg_wr && bus_ok) begin
			case (reg_addr)
				TRIM_ENABLE_ADDR: begin
					st_d.trim_en = reg_wdata[TRIM_ENABLE_BIT];
				end
				TRIM_AMOUNT_ADDR: begin
					st_d.trim_amount = reg_wdata[TRIM_AMOUNT_LSB +: TRIM_AMOUNT_W];
					st_d.trim_sign   = reg_wdata[TRIM_SIGN_BIT];
				end
				CLOCK_OUTPUT_ADDR: begin
					st_d.clk_mask = reg_wdata[CLK_MASK_BIT];
				end
				default: begin
				end
			endcase
		end

		if (reg_rd) begin
			st_d.rdata = 8'h00;
			if (bus_ok) begin
				case (reg_addr)
					TRIM_ENABLE_ADDR: begin
						st_d.rdata[TRIM_ENABLE_BIT] = st_q.trim_en;
					end
					TRIM_AMOUNT_ADDR: begin
						st_d.rdata[TRIM_AMOUNT_LSB +: TRIM_AMOUNT_W] = st_q.trim_amount;
						st_d.rdata[TRIM_SIGN_BIT] = st_q.trim_sign;
					end
					CLOCK_OUTPUT_ADDR: begin
						st_d.rdata[CLK_MASK_BIT] = st_q.clk_mask;
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ***************************************************************
	// state register
	// ***************************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign reg_rdata  = st_q.rdata;
	assign clk32k_out = st_q.clk_out;
	assign sec_pulse  = st_q.pulse;
	assign sec_count  = st_q.secs;

	// ***************************************************************
	// checks
	// ***************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	chk_untrimmed_step: assert property (sec_tick && !st_q.trim_en
		|=> sec_count == $past(sec_count) + SEC_W'(1))
		else $error("untrimmed second did not step by one");
	chk_window_limit: assert property (sec_tick && st_q.win_cnt >= st_q.trim_amount
		|=> sec_count == $past(sec_count) + SEC_W'(1))
		else $error("trim applied outside the amount window");
	chk_trim_add: assert property (sec_tick && trim_hit && !st_q.trim_sign
		|=> sec_pulse && sec_count == $past(sec_count, 1) + SEC_W'(2))
		else $error("add trim did not step by two");
	chk_trim_sub: assert property (sec_tick && trim_hit && st_q.trim_sign
		|=> !sec_pulse && $stable(sec_count))
		else $error("subtract trim did not hold the count");
	chk_pulse_counted: assert property (sec_tick && !(trim_hit && st_q.trim_sign)
		|=> sec_pulse)
		else $error("counted second gave no pulse");
	chk_count_idle: assert property (!sec_tick |=> !sec_pulse && $stable(sec_count))
		else $error("seconds moved without a tick");
	chk_clock_output_ctrl_mask: assert property (st_q.clk_mask |=> !clk32k_out)
		else $error("masked clock output toggled");
	chk_mask_write: assert property (reg_wr && bus_ok && reg_addr == CLOCK_OUTPUT_ADDR
		|=> st_q.clk_mask == $past(reg_wdata[CLK_MASK_BIT]))
		else $error("mask bit write not taken");
	chk_reset_zero: assert property ($rose(rst_n)
		|-> !st_q.trim_en && st_q.trim_amount == '0 && !st_q.trim_sign && !st_q.clk_mask)
		else $error("registers not zero after reset");
	chk_trim_readback: assert property (reg_wr && bus_ok && reg_addr == TRIM_AMOUNT_ADDR
		##1 !reg_wr
		##1 reg_rd && bus_ok && reg_addr == TRIM_AMOUNT_ADDR && !reg_wr
		|=> reg_rdata == ($past(reg_wdata, 3) & 8'h7f))
		else $error("trim register readback wrong");
	chk_reserved_zero: assert property (reg_rd |=> !reg_rdata[7])
		else $error("reserved bit read back set");
	chk_backup_hold: assert property (backup
		|=> $stable(st_q.trim_en) && $stable(st_q.clk_mask) && !clk32k_out)
		else $error("backup state touched registers or clock pin");
	chk_backup_read: assert property (reg_rd && backup |=> reg_rdata == 8'h00)
		else $error("read on backup returned data");
	chk_backup_count: assert property (backup && sec_tick && !trim_hit
		|=> sec_count == $past(sec_count) + SEC_W'(1))
		else $error("seconds stopped on backup power");

	cov_add_second: cover property (sec_tick && trim_hit && !st_q.trim_sign);
	cov_sub_second: cover property (sec_tick && trim_hit && st_q.trim_sign);
	cov_mask_set: cover property (reg_wr && reg_addr == CLOCK_OUTPUT_ADDR && reg_wdata[0]);
	cov_backup_tick: cover property (backup && sec_tick);
	cov_trim_read: cover property (reg_rd && bus_ok && reg_addr == TRIM_AMOUNT_ADDR);

endmodule
`default_nettype wire

// >>> testbench/rtctc_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module rtctc_top_tb;
	import rtctc_pkg::*;
	localparam int TPS     = 2;
	localparam int SEC_CYC = TPS * 2 * HALF_CYC;
	logic             clk       = 1'b0;
	logic             resetn    = 1'b0;
	logic             on_backup = 1'b0;
	logic             reg_wr    = 1'b0;
	logic             reg_rd    = 1'b0;
	logic [7:0]       reg_addr  = 8'h00;
	logic [7:0]       reg_wdata = 8'h00;
	logic [7:0]       reg_rdata;
	logic [7:0]       d;
	logic [7:0]       a;
	logic             clk32k_out;
	logic             sec_pulse;
	logic [SEC_W-1:0] sec_count;
	int               errors    = 0;
	int               compares  = 0;
	int               pulses    = 0;
	int               seed      = 32'h1647;
	int               i;
	always #5 clk = ~clk;
	// counted on the falling edge, where the registered pulse is settled
	always @(negedge clk) pulses += sec_pulse;
	rtctc_top #(.TICKS_PER_SEC(TPS)) dut (.clk(clk), .resetn(resetn), .on_backup(on_backup),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .clk32k_out(clk32k_out), .sec_pulse(sec_pulse),
		.sec_count(sec_count));
	// ***************************************************************
	// tasks
	// ***************************************************************
	task automatic stop_test;
		$display("compares=%0d errors=%0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	task automatic rst;
		resetn = 1'b0;
		repeat (8) @(posedge clk);
		#1 resetn = 1'b1;
		// wait three edges; the first request is sampled on the fifth edge after release
		repeat (3) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
		@(posedge clk);
		#1;
		reg_addr  = ad;
		reg_wdata = wd;
		reg_wr    = 1'b1;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] ad, output logic [7:0] rd_d);
		@(posedge clk);
		#1;
		reg_addr = ad;
		reg_rd   = 1'b1;
		@(posedge clk);
		#1;
		reg_rd = 1'b0;
		rd_d   = reg_rdata;
	endtask
	function automatic logic [7:0] mask_of(input logic [7:0] ad);
		case (ad)
			8'h1f, 8'h21: return 8'h01;
			8'h20: return 8'h7f;
			default: return 8'h00;
		endcase
	endfunction
	function automatic int exp_cnt(input logic [7:0] en, input logic [7:0] tr, input int k);
		int e = 0;
		for (int s = 0; s < k; s++)
			e += (en[0] && s < tr[5:0]) ? (tr[6] ? 0 : 2) : 1;
		return e;
	endfunction
	// a swallowed second gives no pulse, every other second one
	function automatic int exp_pls(input logic [7:0] en, input logic [7:0] tr, input int k);
		int e = 0;
		for (int s = 0; s < k; s++)
			e += (en[0] && s < tr[5:0] && tr[6]) ? 0 : 1;
		return e;
	endfunction
	// high time over one full period: exactly half when running, none when silenced
	task automatic clk_chk(input logic on);
		int hi = 0;
		repeat (5) @(posedge clk);
		repeat (2 * HALF_CYC) begin
			@(negedge clk);
			hi += clk32k_out;
		end
		chk(hi, on ? HALF_CYC : 0, "clock out");
	endtask
	// sample mid-second so the tick phase does not matter
	task automatic secs(input logic [7:0] en, input logic [7:0] tr, input logic bk, input int n);
		int p0;
		wr(8'h1f, en);
		wr(8'h20, tr);
		on_backup = bk;
		p0 = pulses;
		repeat (SEC_CYC / 2 - 4) @(posedge clk);
		for (int k = 0; k < n; k++) begin
			#1 chk(sec_count, exp_cnt(en, tr, k), "seconds");
			chk(pulses - p0, exp_pls(en, tr, k), "pulses");
			repeat (SEC_CYC) @(posedge clk);
		end
		$display("seconds test en=%h trim=%h done", en, tr);
	endtask
	// ***************************************************************
	// sequence
	// ***************************************************************
	initial begin
		#950000 errors++;
		$display("[FAIL] %0t timeout", $time);
		stop_test();
	end
	initial begin
		rst();
		for (i = 0; i < 4; i++) begin
			rd(8'h1f + i[7:0], d);
			chk(d, 8'h00, "reset value");
		end
		wr(8'h20, 8'hc5);
		rd(8'h20, d);
		chk(d, 8'h45, "reserved bit");
		for (i = 0; i < 16; i++) begin
			a = 8'h1f + 8'($unsigned($random(seed)) % 4);
			wr(a, 8'($random(seed)));
			rd(a, d);
			chk(d, reg_wdata & mask_of(a), "readback");
		end
		$display("register test done");
		wr(8'h21, 8'h00);
		clk_chk(1'b1);
		wr(8'h21, 8'hff);
		clk_chk(1'b0);
		wr(8'h21, 8'h00);
		wr(8'h20, 8'h2a);
		#1 on_backup = 1'b1;
		repeat (5) @(posedge clk);
		wr(8'h20, 8'h15);
		rd(8'h20, d);
		chk(d, 8'h00, "backup read");
		clk_chk(1'b0);
		#1 on_backup = 1'b0;
		repeat (5) @(posedge clk);
		rd(8'h20, d);
		chk(d, 8'h2a, "kept value");
		$display("clock and backup test done");
		rst();
		secs(8'h00, 8'h7f, 1'b1, 2);
		on_backup = 1'b0;
		rst();
		secs(8'h01, 8'h02, 1'b0, 3);
		rst();
		secs(8'h01, 8'h41, 1'b0, 3);
		stop_test();
	end
endmodule
`default_nettype wire
